// ---- inc/mei_pkg.sv ----
/*
  Constants for the metering event interrupt and checksum status block.
  Assumes a serial front end that turns host frames into single-cycle register strobes on clk_i.
*/
// How it works
// - enable0 bits 15..13 gate over-current A/B/C
// - enable0 bits 12..10 gate over-voltage A/B/C
// - enable0 bit 9 gates voltage sequence error
// - enable0 bit 8 gates current sequence error
// - enable0 bit 7 gates neutral over-current
// - enable0 bits 6..4 gate no-load changes
// - enable0 bits 3..0 gate pulse direction changes
// - enable1 bit 15 gates frequency-high change
// - enable1 bit 11 gates frequency-low change
// - enable1 bits 14..12 gate sag A/B/C
// - enable1 bits 10..8 gate phase loss A/B/C
// - enable1 bits 7..4 gate reactive sign changes
// - enable1 bits 3..0 gate active sign changes
// - last serial access data kept read-only
// - checksum status bit 0 configuration mismatch
// - checksum status bit 1 internal mismatch
// - digest reads golden, writes only when permitted
// - golden write needs unlock value AA55
// - unlock values other than 55AA latch golden and compare
// - flags set on change, write one clears
package mei_pkg;
  localparam int MEI_ADDR_W = 10;
  localparam int MEI_DATA_W = 16;
  localparam logic [9:0] MEI_OFS_FLAGS_0 = 10'h073;
  localparam logic [9:0] MEI_OFS_FLAGS_1 = 10'h074;
  localparam logic [9:0] MEI_OFS_ENABLE_0 = 10'h075;
  localparam logic [9:0] MEI_OFS_ENABLE_1 = 10'h076;
  localparam logic [9:0] MEI_OFS_LAST_ACCESS = 10'h078;
  localparam logic [9:0] MEI_OFS_CHK_ERR = 10'h079;
  localparam logic [9:0] MEI_OFS_DIGEST = 10'h07A;
  localparam logic [9:0] MEI_OFS_UNLOCK = 10'h07F;
  localparam logic [15:0] MEI_UNLOCK_CONFIG = 16'h55AA;
  localparam logic [15:0] MEI_UNLOCK_GOLDEN_WR = 16'hAA55;
  localparam logic [15:0] MEI_RST_WORD = 16'h0000;
  localparam int MEI_CHK_CFG_BIT = 0;
  localparam int MEI_CHK_INT_BIT = 1;
  typedef enum logic [1:0]
  {
    MEI_CHK_HOLD = 2'b00,
    MEI_CHK_LATCH = 2'b01,
    MEI_CHK_RUN = 2'b10
  } mei_chk_state_t;
endpackage

// ---- src/mei_flag_bank.sv ----
/*
  Bank of sticky status-change flags: a flag sets when its condition input changes level and
  clears when the host writes one to it. Conditions come from logic on the same clock.
*/
module mei_flag_bank #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] cond_i,
  input wire logic clear_i,
  input wire logic [WIDTH-1:0] clear_mask_i,
  output logic [WIDTH-1:0] flags_o
);
  import mei_pkg::*;

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;
  logic primed_reg;
  logic primed_next;
  logic [WIDTH-1:0] change;

  initial
  begin
    if (WIDTH < 1) $error("flag bank width must be at least one");
  end

  // the first sampled level after reset is a reference, not a change
  always_comb
  begin
    change = primed_reg ? (cond_i ^ prev_reg) : '0;
    prev_next = cond_i;
    primed_next = 1'b1;
    flags_next = flags_reg;
    if (clear_i)
    begin
      flags_next = flags_reg & ~clear_mask_i;
    end
    flags_next = flags_next | change; // set beats a same-cycle clear
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_reg <= '0;
      flags_reg <= '0;
      primed_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= prev_next;
      flags_reg <= flags_next;
      primed_reg <= primed_next;
    end
  end

  assign flags_o = flags_reg;

  flag_sets_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    primed_reg && (cond_i != prev_reg) |=>
    ((flags_o & ($past(cond_i) ^ $past(prev_reg))) == ($past(cond_i) ^ $past(prev_reg))))
    else $error("change did not set its flag");
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!clear_i && cond_i == prev_reg) |=> (flags_o == $past(flags_o)))
    else $error("flag moved without change or clear");
  flag_cleared_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clear_i && primed_reg && cond_i == prev_reg) |=> ((flags_o & $past(clear_mask_i)) == '0))
    else $error("write one did not clear flag");
  cover property (@(posedge clk_i) disable iff (!reset_n_i) clear_i && primed_reg && ((cond_i ^ prev_reg) != '0));
endmodule

// ---- src/mei_event_irq.sv ----
/*
  Metering event interrupt enables, status-change flags and checksum integrity registers.
  Assumes the serial front end presents one-cycle read and write strobes with a word address,
  supplies the read data of registers held elsewhere, and that event levels and checksum
  results come from the metering core on the same clock.
*/
module mei_event_irq (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [mei_pkg::MEI_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [mei_pkg::MEI_DATA_W-1:0] reg_wdata_i,
  input wire logic [mei_pkg::MEI_DATA_W-1:0] ext_rdata_i,
  output logic [mei_pkg::MEI_DATA_W-1:0] reg_rdata_o,
  output logic reg_hit_o,
  input wire logic [15:0] event_cond_0_i,
  input wire logic [15:0] event_cond_1_i,
  input wire logic [15:0] cfg_checksum_i,
  input wire logic cfg_checksum_valid_i,
  input wire logic internal_checksum_err_i,
  output logic [15:0] golden_checksum_o,
  output logic config_mode_o,
  output logic irq_o
);
  import mei_pkg::*;

  localparam logic [15:0] RESERVED_MASK = 16'h0003;

  logic [15:0] enable_0_reg;
  logic [15:0] enable_0_next;
  logic [15:0] enable_1_reg;
  logic [15:0] enable_1_next;
  logic [15:0] unlock_reg;
  logic [15:0] unlock_next;
  logic [15:0] last_access_reg;
  logic [15:0] last_access_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic hit_reg;
  logic hit_next;
  logic [15:0] golden_reg;
  logic [15:0] golden_next;
  logic [1:0] chk_err_reg;
  logic [1:0] chk_err_next;
  mei_chk_state_t chk_state_reg;
  mei_chk_state_t chk_state_next;
  logic [15:0] flags_0;
  logic [15:0] flags_1;
  logic [15:0] read_word;
  logic read_hit;
  logic wr_flags_0;
  logic wr_flags_1;
  logic golden_wr_ok;

  function automatic logic addr_is(input logic [MEI_ADDR_W-1:0] addr, input logic [9:0] ofs);
    addr_is = (addr == MEI_ADDR_W'(ofs));
  endfunction

  function automatic logic is_special(input logic [15:0] code);
    is_special = (code == MEI_UNLOCK_CONFIG) || (code == MEI_UNLOCK_GOLDEN_WR);
  endfunction

  initial
  begin
    if (MEI_ADDR_W < 10) $error("register address too narrow for the map");
    if (MEI_DATA_W != 16) $error("registers are sixteen bits wide");
  end

  assign wr_flags_0 = reg_wr_i && addr_is(reg_addr_i, MEI_OFS_FLAGS_0);
  assign wr_flags_1 = reg_wr_i && addr_is(reg_addr_i, MEI_OFS_FLAGS_1);

  // enable registers never touch the flags, they only mask them
  mei_flag_bank #(
    .WIDTH(16)
  ) u_flags_0 (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cond_i(event_cond_0_i),
    .clear_i(wr_flags_0),
    .clear_mask_i(reg_wdata_i),
    .flags_o(flags_0)
  );

  mei_flag_bank #(
    .WIDTH(16)
  ) u_flags_1 (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cond_i(event_cond_1_i),
    .clear_i(wr_flags_1),
    .clear_mask_i(reg_wdata_i),
    .flags_o(flags_1)
  );

  // digest portal only takes writes under the golden-write unlock code
  assign golden_wr_ok = reg_wr_i && addr_is(reg_addr_i, MEI_OFS_DIGEST) && (unlock_reg == MEI_UNLOCK_GOLDEN_WR);

  // read mux; unmapped addresses pass the outside register's data through
  always_comb
  begin
    read_word = ext_rdata_i;
    read_hit = 1'b1;
    if (addr_is(reg_addr_i, MEI_OFS_FLAGS_0))
    begin
      read_word = flags_0;
    end
    else if (addr_is(reg_addr_i, MEI_OFS_FLAGS_1))
    begin
      read_word = flags_1;
    end
    else if (addr_is(reg_addr_i, MEI_OFS_ENABLE_0))
    begin
      read_word = enable_0_reg;
    end
    else if (addr_is(reg_addr_i, MEI_OFS_ENABLE_1))
    begin
      read_word = enable_1_reg;
    end
    else if (addr_is(reg_addr_i, MEI_OFS_LAST_ACCESS))
    begin
      read_word = last_access_reg;
    end
    else if (addr_is(reg_addr_i, MEI_OFS_CHK_ERR))
    begin
      read_word = {14'h0000, chk_err_reg} & RESERVED_MASK; // reserved bits always read zero
    end
    else if (addr_is(reg_addr_i, MEI_OFS_DIGEST))
    begin
      read_word = golden_reg;
    end
    else if (addr_is(reg_addr_i, MEI_OFS_UNLOCK))
    begin
      read_word = unlock_reg;
    end
    else
    begin
      read_hit = 1'b0;
    end
  end

  // register file; read-only addresses ignore writes, but a write to the last-access address is logged there like any other
  always_comb
  begin
    enable_0_next = enable_0_reg;
    enable_1_next = enable_1_reg;
    unlock_next = unlock_reg;
    last_access_next = last_access_reg;
    rdata_next = rdata_reg;
    hit_next = hit_reg;
    if (reg_wr_i)
    begin
      if (addr_is(reg_addr_i, MEI_OFS_ENABLE_0))
      begin
        enable_0_next = reg_wdata_i;
      end
      else if (addr_is(reg_addr_i, MEI_OFS_ENABLE_1))
      begin
        enable_1_next = reg_wdata_i;
      end
      else if (addr_is(reg_addr_i, MEI_OFS_UNLOCK))
      begin
        unlock_next = reg_wdata_i;
      end
      last_access_next = reg_wdata_i;
    end
    else if (reg_rd_i)
    begin
      rdata_next = read_word;
      hit_next = read_hit;
      // clear-on-read registers outside are logged with the value handed out
      if (!addr_is(reg_addr_i, MEI_OFS_LAST_ACCESS))
      begin
        last_access_next = read_word;
      end
    end
  end

  // golden checksum tracking; leaving configuration mode re-latches a fresh golden value
  always_comb
  begin
    chk_state_next = chk_state_reg;
    golden_next = golden_reg;
    chk_err_next = chk_err_reg;
    chk_err_next[MEI_CHK_INT_BIT] = internal_checksum_err_i;
    case (chk_state_reg)
      MEI_CHK_HOLD:
      begin
        chk_err_next[MEI_CHK_CFG_BIT] = 1'b0;
        if (unlock_reg != MEI_UNLOCK_CONFIG)
        begin
          chk_state_next = MEI_CHK_LATCH;
        end
      end
      MEI_CHK_LATCH:
      begin
        if (unlock_reg == MEI_UNLOCK_CONFIG)
        begin
          chk_state_next = MEI_CHK_HOLD;
        end
        else if (cfg_checksum_valid_i)
        begin
          golden_next = cfg_checksum_i;
          chk_state_next = MEI_CHK_RUN;
        end
      end
      MEI_CHK_RUN:
      begin
        if (unlock_reg == MEI_UNLOCK_CONFIG)
        begin
          chk_state_next = MEI_CHK_HOLD;
        end
        else if (cfg_checksum_valid_i)
        begin
          chk_err_next[MEI_CHK_CFG_BIT] = (cfg_checksum_i != golden_reg);
        end
      end
      default:
      begin
        chk_state_next = MEI_CHK_HOLD;
      end
    endcase
    if (golden_wr_ok)
    begin
      golden_next = reg_wdata_i;
      chk_state_next = MEI_CHK_RUN;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      enable_0_reg <= MEI_RST_WORD;
      enable_1_reg <= MEI_RST_WORD;
      unlock_reg <= MEI_RST_WORD;
      last_access_reg <= MEI_RST_WORD;
      rdata_reg <= MEI_RST_WORD;
      hit_reg <= 1'b0;
      golden_reg <= MEI_RST_WORD;
      chk_err_reg <= 2'b00;
      chk_state_reg <= MEI_CHK_HOLD;
    end
    else
    begin
      enable_0_reg <= enable_0_next;
      enable_1_reg <= enable_1_next;
      unlock_reg <= unlock_next;
      last_access_reg <= last_access_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      golden_reg <= golden_next;
      chk_err_reg <= chk_err_next;
      chk_state_reg <= chk_state_next;
    end
  end

  // bit positions of flags and enables match one for one, so a plain and gives the gating
  assign irq_o = |(flags_0 & enable_0_reg) || |(flags_1 & enable_1_reg);
  assign reg_rdata_o = rdata_reg;
  assign reg_hit_o = hit_reg;
  assign golden_checksum_o = golden_reg;
  assign config_mode_o = (unlock_reg == MEI_UNLOCK_CONFIG) && !is_special(16'h0000);

  irq_gate_0_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (flags_0[15:13] & enable_0_reg[15:13]) != 3'b000 |-> irq_o)
    else $error("over-current flag with enable did not raise irq");
  irq_gate_1_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (flags_1[15] && enable_1_reg[15]) || (flags_1[11] && enable_1_reg[11]) |-> irq_o)
    else $error("frequency flag with enable did not raise irq");
  irq_masked_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ((flags_0 & enable_0_reg) == 16'h0000) && ((flags_1 & enable_1_reg) == 16'h0000) |-> !irq_o)
    else $error("irq raised with every flag masked");
  enable_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr_i && addr_is(reg_addr_i, MEI_OFS_ENABLE_0) |=> enable_0_reg == $past(reg_wdata_i))
    else $error("enable register did not take write");
  enable_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(reg_wr_i && addr_is(reg_addr_i, MEI_OFS_ENABLE_0)) |=> enable_0_reg == $past(enable_0_reg))
    else $error("enable register moved without write");
  last_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr_i |=> last_access_reg == $past(reg_wdata_i))
    else $error("last access did not log written word");
  last_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_rd_i && !reg_wr_i && !addr_is(reg_addr_i, MEI_OFS_LAST_ACCESS) |=> last_access_reg == reg_rdata_o)
    else $error("last access differs from read data");
  golden_guard_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr_i && addr_is(reg_addr_i, MEI_OFS_DIGEST) && unlock_reg != MEI_UNLOCK_GOLDEN_WR && !cfg_checksum_valid_i
    |=> golden_reg == $past(golden_reg))
    else $error("golden value changed without unlock");
  golden_take_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    golden_wr_ok |=> golden_reg == $past(reg_wdata_i))
    else $error("permitted digest write not taken");
  cfg_mismatch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    chk_state_reg == MEI_CHK_RUN && cfg_checksum_valid_i && unlock_reg != MEI_UNLOCK_CONFIG && !golden_wr_ok
    |=> chk_err_reg[MEI_CHK_CFG_BIT] == ($past(cfg_checksum_i) != $past(golden_reg)))
    else $error("configuration mismatch bit wrong");
  int_err_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    internal_checksum_err_i ##1 internal_checksum_err_i |-> chk_err_reg[MEI_CHK_INT_BIT])
    else $error("internal checksum error not reported");
  relatch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    chk_state_reg == MEI_CHK_LATCH && cfg_checksum_valid_i && unlock_reg != MEI_UNLOCK_CONFIG && !golden_wr_ok
    |=> golden_reg == $past(cfg_checksum_i) && chk_state_reg == MEI_CHK_RUN)
    else $error("golden value not latched in normal mode");

  irq_seen_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(irq_o));
  golden_wr_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) golden_wr_ok);
  mismatch_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(chk_err_reg[MEI_CHK_CFG_BIT]));
  config_c: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    chk_state_reg == MEI_CHK_RUN ##1 chk_state_reg == MEI_CHK_HOLD);
endmodule

// ---- test/mei_event_irq_test.sv ----
/*
  Self-checking bench for mei_event_irq: register table walk, per-bit event mask loop,
  checksum latch/compare/unlock cases and a reset in mid-run.
  Assumes mei_pkg is compiled first and the design runs on one 250 MHz clock.
*/
module mei_event_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mei_pkg::*;

  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [MEI_ADDR_W-1:0] reg_addr_i = '0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] ext_rdata_i = 16'h0000;
  logic [15:0] cond0 = 16'h0000;
  logic [15:0] cond1 = 16'h0000;
  logic [15:0] cs = 16'h0000;
  logic cs_valid = 1'h0;
  logic int_err = 1'h0;
  logic [15:0] reg_rdata_o;
  logic reg_hit_o;
  logic [15:0] golden_checksum_o;
  logic config_mode_o;
  logic irq_o;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] rdv;
  logic hitv;
  logic [15:0] m;
  logic [9:0] ea;
  logic [9:0] fa;
  // rows: address, write data, expected read back
  logic [41:0] rows [7] = '{
    {MEI_OFS_ENABLE_0, 16'hFFFF, 16'hFFFF}, {MEI_OFS_ENABLE_0, 16'h0000, 16'h0000},
    {MEI_OFS_ENABLE_1, 16'hA5A5, 16'hA5A5}, {MEI_OFS_ENABLE_1, 16'h0000, 16'h0000},
    {MEI_OFS_UNLOCK, 16'h1234, 16'h1234}, {MEI_OFS_CHK_ERR, 16'hFFFF, 16'h0000},
    {MEI_OFS_DIGEST, 16'hFFFF, 16'h0000}};

  mei_event_irq u_mei_event_irq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .ext_rdata_i(ext_rdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_hit_o(reg_hit_o),
    .event_cond_0_i(cond0),
    .event_cond_1_i(cond1),
    .cfg_checksum_i(cs),
    .cfg_checksum_valid_i(cs_valid),
    .internal_checksum_err_i(int_err),
    .golden_checksum_o(golden_checksum_o),
    .config_mode_o(config_mode_o),
    .irq_o(irq_o)
  );

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [9:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    #1;
    rdv = reg_rdata_o;
    hitv = reg_hit_o;
  endtask

  // checksum result is taken at the edge that sees the strobe, so look one step later
  task automatic pulse(input logic [15:0] v);
    @(posedge clk_i);
    cs_valid <= 1'h1;
    cs <= v;
    @(posedge clk_i);
    cs_valid <= 1'h0;
    #1;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (50000) @(posedge clk_i);
    error_cnt++;
    results();
  end

  initial
  begin
    tick(2);
    chk(reg_rdata_o, 16'h0000);
    chk(golden_checksum_o, 16'h0000);
    chk({13'h0000, reg_hit_o, config_mode_o, irq_o}, 16'h0000);
    @(posedge clk_i);
    reset_n_i <= 1'h1;
    rd(MEI_OFS_ENABLE_0);
    chk(rdv, 16'h0000);
    rd(MEI_OFS_ENABLE_1);
    chk(rdv, 16'h0000);
    $display("test reset done");
    for (int r = 0; r < 7; r++)
    begin
      wr(rows[r][41:32], rows[r][31:16]);
      rd(rows[r][41:32]);
      chk(rdv, rows[r][15:0]);
      chk({15'h0000, hitv}, 16'h0001);
      rd(MEI_OFS_LAST_ACCESS);
      chk(rdv, rows[r][15:0]);
    end
    wr(MEI_OFS_UNLOCK, 16'h0000);
    wr(10'h100, 16'h1234);
    rd(MEI_OFS_LAST_ACCESS);
    chk(rdv, 16'h1234);
    @(posedge clk_i);
    ext_rdata_i <= 16'hBEEF;
    rd(10'h100);
    chk(rdv, 16'hBEEF);
    chk({15'h0000, hitv}, 16'h0000);
    rd(MEI_OFS_LAST_ACCESS);
    chk(rdv, 16'hBEEF);
    $display("test register table done");
    // each bit: masked change sets only its flag, unmasking raises irq, write one clears
    for (int i = 0; i < 32; i++)
    begin
      m = 16'h0001 << (i % 16);
      ea = (i < 16) ? MEI_OFS_ENABLE_0 : MEI_OFS_ENABLE_1;
      fa = (i < 16) ? MEI_OFS_FLAGS_0 : MEI_OFS_FLAGS_1;
      wr(ea, ~m);
      @(posedge clk_i);
      if (i < 16)
        cond0 <= cond0 ^ m;
      else
        cond1 <= cond1 ^ m;
      tick(3);
      chk({15'h0000, irq_o}, 16'h0000);
      rd(fa);
      chk(rdv, m);
      wr(ea, m);
      chk({15'h0000, irq_o}, 16'h0001);
      wr(fa, m);
      chk({15'h0000, irq_o}, 16'h0000);
      rd(fa);
      chk(rdv, 16'h0000);
      wr(ea, 16'h0000);
    end
    @(posedge clk_i);
    cond0 <= 16'h0000;
    tick(3);
    rd(MEI_OFS_FLAGS_0);
    chk(rdv, 16'hFFFF);
    wr(MEI_OFS_ENABLE_0, 16'hFFFF);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(MEI_OFS_FLAGS_0, 16'hFFFF);
    chk({15'h0000, irq_o}, 16'h0000);
    $display("test event mask done");
    pulse(16'h1111);
    chk(golden_checksum_o, 16'h1111);
    rd(MEI_OFS_DIGEST);
    chk(rdv, 16'h1111);
    pulse(16'h2222);
    rd(MEI_OFS_CHK_ERR);
    chk(rdv, 16'h0001);
    pulse(16'h1111);
    rd(MEI_OFS_CHK_ERR);
    chk(rdv, 16'h0000);
    @(posedge clk_i);
    int_err <= 1'h1;
    tick(2);
    rd(MEI_OFS_CHK_ERR);
    chk(rdv, 16'h0002);
    @(posedge clk_i);
    int_err <= 1'h0;
    wr(MEI_OFS_DIGEST, 16'h3333);
    chk(golden_checksum_o, 16'h1111);
    wr(MEI_OFS_UNLOCK, MEI_UNLOCK_GOLDEN_WR);
    wr(MEI_OFS_DIGEST, 16'h3333);
    chk(golden_checksum_o, 16'h3333);
    pulse(16'h5555);
    rd(MEI_OFS_CHK_ERR);
    chk(rdv, 16'h0001);
    wr(MEI_OFS_UNLOCK, MEI_UNLOCK_CONFIG);
    chk({15'h0000, config_mode_o}, 16'h0001);
    wr(MEI_OFS_UNLOCK, 16'h0000);
    chk({15'h0000, config_mode_o}, 16'h0000);
    tick(2);
    rd(MEI_OFS_CHK_ERR);
    chk(rdv, 16'h0000);
    pulse(16'h4444);
    chk(golden_checksum_o, 16'h4444);
    $display("test checksum done");
    @(posedge clk_i);
    cond0 <= 16'h8000;
    tick(3);
    chk({15'h0000, irq_o}, 16'h0001);
    @(posedge clk_i);
    reset_n_i <= 1'h0;
    #1;
    chk({15'h0000, irq_o}, 16'h0000);
    @(posedge clk_i);
    reset_n_i <= 1'h1;
    rd(MEI_OFS_ENABLE_0);
    chk(rdv, 16'h0000);
    rd(MEI_OFS_FLAGS_0);
    chk(rdv, 16'h0000);
    chk({15'h0000, irq_o}, 16'h0000);
    $display("test mid-run reset done");
    results();
  end
endmodule
